// ### pkg/uls_pkg.sv
// Shared constants for the UART line and modem status block
package uls_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int MDM_N = 4;
  localparam int INT_N = 3;

  // Register offsets
  localparam logic [3:0] OFS_LINE_STATUS = 4'h0;
  localparam logic [3:0] OFS_MODEM_STATUS = 4'h1;
  localparam logic [3:0] OFS_MODEM_CTRL = 4'h2;
  localparam logic [3:0] OFS_FEATURE = 4'h3;
  localparam logic [3:0] OFS_INT_STATUS = 4'h4;
  localparam logic [3:0] OFS_INT_CLEAR = 4'h5;
  localparam logic [3:0] OFS_INT_ENABLE = 4'h6;

  // Line status fields
  localparam int LS_READY_BIT = 0;
  localparam int LS_OVERRUN_BIT = 1;
  localparam int LS_PARITY_BIT = 2;

  // Modem input index inside the 4-bit vectors
  localparam int MDM_CTS = 0;
  localparam int MDM_DSR = 1;
  localparam int MDM_RI = 2;
  localparam int MDM_CD = 3;

  // Modem control fields
  localparam int MC_DTR_BIT = 0;
  localparam int MC_RTS_BIT = 1;
  localparam int MC_OUT1_BIT = 2;
  localparam int MC_OUT2_BIT = 3;
  localparam int MC_LOOP_BIT = 4;

  // Enhanced feature field
  localparam int FEAT_AUTO_CTS_BIT = 7;

  // Interrupt status fields
  localparam int INT_MODEM_BIT = 0;
  localparam int INT_OVERRUN_BIT = 1;
  localparam int INT_PARITY_BIT = 2;

  // Reset values
  localparam logic [7:0] MODEM_CTRL_RST = 8'h00;
  localparam logic [7:0] FEATURE_RST = 8'h00;
  localparam logic [2:0] INT_RST = 3'h0;
  localparam logic [3:0] MDM_ACT_RST = 4'h0;
  localparam logic PIN_IDLE = 1'b1;
endpackage

// ### verilog/uls_pin_filter.sv
// Three-stage synchroniser with agreement filter for one modem pin
module uls_pin_filter (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic pin_i,
  output logic level_o
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic level_reg;
  logic agree;

  // Only s2 and s3 are compared; s1 may be metastable
  assign agree = (s2_reg == s3_reg);

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_reg <= uls_pkg::PIN_IDLE;
      s2_reg <= uls_pkg::PIN_IDLE;
      s3_reg <= uls_pkg::PIN_IDLE;
      level_reg <= uls_pkg::PIN_IDLE;
    end else begin
      s1_reg <= pin_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (agree) begin
        level_reg <= s3_reg;
      end
    end
  end

  assign level_o = level_reg;
endmodule

// ### verilog/uls_status.sv
// UART line status flags, modem status register and CTS flow stop
// Notes on behaviour
// - Parity flag reports the parity of the oldest held character.
// - Overrun flag sets when a character completes while FIFO full.
// - On overrun the new character is not pushed into the FIFO.
// - Data ready is high while any received character is held.
// - Each modem input change sets its change indicator; ring sets on one edge only.
// - Reading modem status clears all change indicators.
// - Carrier bit is inverse pin, or user output 2 in loop-back.
// - Ring bit is inverse pin, or user output 1 in loop-back.
// - Data set ready bit is inverse pin, or DTR in loop-back.
// - Clear-to-send bit is inverse pin, or RTS in loop-back.
// - With flow control, CTS high stops transmit after current char.
// - Carrier change sets its indicator and raises modem interrupt.
// - Ring indicator sets only on pin going low to high.
// - Modem interrupt is asserted while any change indicator is set.
// - Auto CTS works only with feature bit 7 set; off at reset.
module uls_status (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic rx_done_i,
  input wire logic rx_fifo_full_i,
  input wire logic rx_avail_i,
  input wire logic rx_top_perr_i,
  output logic rx_push_o,
  input wire logic tx_busy_i,
  output logic tx_stop_o,
  input wire logic cd_n_i,
  input wire logic ri_n_i,
  input wire logic dsr_n_i,
  input wire logic cts_n_i,
  output logic modem_irq_o,
  output logic irq_o
);
  logic [3:0] pins_n;
  logic [3:0] pin_lvl;
  logic [3:0] loop_src;
  logic [3:0] act_sel;
  logic [3:0] act_reg;
  logic [3:0] delta_set;
  logic [3:0] delta_reg;
  logic [3:0] delta_next;
  logic [7:0] mcr_reg;
  logic [7:0] feat_reg;
  logic [2:0] int_sts_reg;
  logic [2:0] int_sts_next;
  logic [2:0] int_en_reg;
  logic [2:0] int_evt;
  logic ready_reg;
  logic perr_reg;
  logic perr_next;
  logic ovr_reg;
  logic ovr_set;
  logic ovr_next;
  logic push_next;
  logic stop_reg;
  logic stop_next;
  logic auto_cts;
  logic loop_on;
  logic sel_ls;
  logic sel_ms;
  logic sel_mc;
  logic sel_ft;
  logic sel_is;
  logic sel_ic;
  logic sel_ie;
  logic rd_ls;
  logic rd_ms;
  logic [7:0] line_word;
  logic [7:0] modem_word;
  logic [7:0] rd_mux;
  logic irq_next;
  logic mirq_next;
  // Clear mask for cycles with no clear write
  localparam logic [2:0] INT_CLR_NONE = 3'h0;

  // Address decode
  assign sel_ls = (addr_i == uls_pkg::OFS_LINE_STATUS);
  assign sel_ms = (addr_i == uls_pkg::OFS_MODEM_STATUS);
  assign sel_mc = (addr_i == uls_pkg::OFS_MODEM_CTRL);
  assign sel_ft = (addr_i == uls_pkg::OFS_FEATURE);
  assign sel_is = (addr_i == uls_pkg::OFS_INT_STATUS);
  assign sel_ic = (addr_i == uls_pkg::OFS_INT_CLEAR);
  assign sel_ie = (addr_i == uls_pkg::OFS_INT_ENABLE);
  assign rd_ls = rd_i && sel_ls;
  assign rd_ms = rd_i && sel_ms;

  // Modem pins, one filter each
  assign pins_n = {cd_n_i, ri_n_i, dsr_n_i, cts_n_i};

  genvar gi;
  generate
    for (gi = 0; gi < uls_pkg::MDM_N; gi++) begin : g_pin
      uls_pin_filter u_filt (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .pin_i(pins_n[gi]),
        .level_o(pin_lvl[gi])
      );
    end
  endgenerate

  // Loop-back routes modem control bits onto the status inputs
  assign loop_on = mcr_reg[uls_pkg::MC_LOOP_BIT];
  assign loop_src = {mcr_reg[uls_pkg::MC_OUT2_BIT],
                     mcr_reg[uls_pkg::MC_OUT1_BIT],
                     mcr_reg[uls_pkg::MC_DTR_BIT],
                     mcr_reg[uls_pkg::MC_RTS_BIT]};
  assign act_sel = loop_on ? loop_src : ~pin_lvl;

  // Change detection against the previous sample
  assign delta_set[uls_pkg::MDM_CTS] =
    act_sel[uls_pkg::MDM_CTS] ^ act_reg[uls_pkg::MDM_CTS];
  assign delta_set[uls_pkg::MDM_DSR] =
    act_sel[uls_pkg::MDM_DSR] ^ act_reg[uls_pkg::MDM_DSR];
  // Pin low to high is the active-high bit falling
  assign delta_set[uls_pkg::MDM_RI] =
    act_reg[uls_pkg::MDM_RI] & ~act_sel[uls_pkg::MDM_RI];
  assign delta_set[uls_pkg::MDM_CD] =
    act_sel[uls_pkg::MDM_CD] ^ act_reg[uls_pkg::MDM_CD];
  // A change in the read cycle survives the clear
  assign delta_next = delta_set | (delta_reg & ~{4{rd_ms}});
  assign mirq_next = |delta_next;

  // Receive side flags
  assign perr_next = rx_top_perr_i && rx_avail_i;
  assign ovr_set = rx_done_i && rx_fifo_full_i;
  assign ovr_next = ovr_set || (ovr_reg && !rd_ls);
  assign push_next = rx_done_i && !rx_fifo_full_i;

  // Flow stop only changes between characters
  assign auto_cts = feat_reg[uls_pkg::FEAT_AUTO_CTS_BIT];
  assign stop_next = tx_busy_i ? stop_reg :
    (auto_cts && !act_reg[uls_pkg::MDM_CTS]);

  // Interrupt events, sticky with set over clear
  assign int_evt[uls_pkg::INT_MODEM_BIT] = |delta_set;
  assign int_evt[uls_pkg::INT_OVERRUN_BIT] = ovr_set;
  assign int_evt[uls_pkg::INT_PARITY_BIT] = perr_next && !perr_reg;
  assign int_sts_next = int_evt |
    (int_sts_reg & ~((wr_i && sel_ic) ? wdata_i[2:0] : INT_CLR_NONE));
  assign irq_next = |(int_sts_next & int_en_reg);

  // Read words; unmapped and write-only offsets read zero
  assign line_word = {5'h00, perr_reg, ovr_reg, ready_reg};
  assign modem_word = {act_reg, delta_reg};
  assign rd_mux = sel_ls ? line_word :
                  sel_ms ? modem_word :
                  sel_mc ? mcr_reg :
                  sel_ft ? feat_reg :
                  sel_is ? {5'h00, int_sts_reg} :
                  sel_ie ? {5'h00, int_en_reg} : 8'h00;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mcr_reg <= uls_pkg::MODEM_CTRL_RST;
      feat_reg <= uls_pkg::FEATURE_RST;
      int_en_reg <= uls_pkg::INT_RST;
    end else if (wr_i) begin
      if (sel_mc) begin
        mcr_reg <= wdata_i;
      end
      if (sel_ft) begin
        feat_reg <= wdata_i;
      end
      if (sel_ie) begin
        int_en_reg <= wdata_i[2:0];
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      act_reg <= uls_pkg::MDM_ACT_RST;
      delta_reg <= uls_pkg::MDM_ACT_RST;
      modem_irq_o <= 1'b0;
    end else begin
      act_reg <= act_sel;
      delta_reg <= delta_next;
      modem_irq_o <= mirq_next;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ready_reg <= 1'b0;
      perr_reg <= 1'b0;
      ovr_reg <= 1'b0;
      rx_push_o <= 1'b0;
    end else begin
      ready_reg <= rx_avail_i;
      perr_reg <= perr_next;
      ovr_reg <= ovr_next;
      rx_push_o <= push_next;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stop_reg <= 1'b0;
      int_sts_reg <= uls_pkg::INT_RST;
      irq_o <= 1'b0;
      rdata_o <= 8'h00;
    end else begin
      stop_reg <= stop_next;
      int_sts_reg <= int_sts_next;
      irq_o <= irq_next;
      rdata_o <= rd_i ? rd_mux : 8'h00;
    end
  end

  assign tx_stop_o = stop_reg;

  // Checks
  // Receive side flags
  chk_ready_follow: assert property (@(posedge ref_clk_i)
    disable iff (!nrst_i) ##1 ready_reg == $past(rx_avail_i))
    else $error("data ready does not follow held data");
  chk_parity_top: assert property (@(posedge ref_clk_i)
    disable iff (!nrst_i)
    ##1 perr_reg == $past(rx_top_perr_i && rx_avail_i))
    else $error("parity flag not that of top character");
  chk_overrun_set: assert property (@(posedge ref_clk_i)
    disable iff (!nrst_i)
    rx_done_i && rx_fifo_full_i |=> ovr_reg && !rx_push_o)
    else $error("overrun not flagged or char pushed");
  chk_ovr_sticky: assert property (@(posedge ref_clk_i)
    disable iff (!nrst_i) ovr_reg && !rd_ls |=> ovr_reg)
    else $error("overrun flag dropped before a read");
  chk_push_normal: assert property (@(posedge ref_clk_i)
    disable iff (!nrst_i)
    rx_done_i && !rx_fifo_full_i |=> rx_push_o)
    else $error("completed character not pushed");
  chk_push_idle: assert property (@(posedge ref_clk_i)
    disable iff (!nrst_i) !rx_done_i |=> !rx_push_o)
    else $error("push without a completed character");

  // Modem status bits and change indicators
  chk_read_clear: assert property (@(posedge ref_clk_i)
    disable iff (!nrst_i)
    rd_ms && delta_set == 4'h0 |=> delta_reg == 4'h0)
    else $error("modem status read did not clear changes");
  chk_delta_hold: assert property (@(posedge ref_clk_i)
    disable iff (!nrst_i) !rd_ms && delta_reg[uls_pkg::MDM_DSR] |=>
    delta_reg[uls_pkg::MDM_DSR])
    else $error("change indicator lost before a read");
  chk_dsr_change: assert property (@(posedge ref_clk_i)
    disable iff (!nrst_i) act_sel[uls_pkg::MDM_DSR] !=
    act_reg[uls_pkg::MDM_DSR] |=> delta_reg[uls_pkg::MDM_DSR])
    else $error("data set ready change not latched");
  chk_loop_cd: assert property (@(posedge ref_clk_i)
    disable iff (!nrst_i) loop_on |=>
    act_reg[uls_pkg::MDM_CD] == $past(mcr_reg[uls_pkg::MC_OUT2_BIT]))
    else $error("loop-back carrier bit wrong");
  chk_loop_ri: assert property (@(posedge ref_clk_i)
    disable iff (!nrst_i) loop_on |=>
    act_reg[uls_pkg::MDM_RI] == $past(mcr_reg[uls_pkg::MC_OUT1_BIT]))
    else $error("loop-back ring bit wrong");
  chk_loop_dsr: assert property (@(posedge ref_clk_i)
    disable iff (!nrst_i) loop_on |=>
    act_reg[uls_pkg::MDM_DSR] == $past(mcr_reg[uls_pkg::MC_DTR_BIT]))
    else $error("loop-back data set ready bit wrong");
  chk_norm_cts: assert property (@(posedge ref_clk_i)
    disable iff (!nrst_i) !loop_on |=>
    act_reg[uls_pkg::MDM_CTS] == !$past(pin_lvl[uls_pkg::MDM_CTS]))
    else $error("clear-to-send bit not inverse of pin");
  chk_cd_change: assert property (@(posedge ref_clk_i)
    disable iff (!nrst_i) delta_set[uls_pkg::MDM_CD] |=>
    delta_reg[uls_pkg::MDM_CD] && modem_irq_o)
    else $error("carrier change not latched");
  chk_ri_rise_only: assert property (@(posedge ref_clk_i)
    disable iff (!nrst_i) !act_reg[uls_pkg::MDM_RI] &&
    act_sel[uls_pkg::MDM_RI] && !delta_reg[uls_pkg::MDM_RI] |=>
    !delta_reg[uls_pkg::MDM_RI])
    else $error("ring indicator set on wrong edge");
  chk_ri_fall_set: assert property (@(posedge ref_clk_i)
    disable iff (!nrst_i) act_reg[uls_pkg::MDM_RI] &&
    !act_sel[uls_pkg::MDM_RI] |=> delta_reg[uls_pkg::MDM_RI] && modem_irq_o)
    else $error("ring trailing edge not latched");
  chk_irq_level: assert property (@(posedge ref_clk_i)
    disable iff (!nrst_i) modem_irq_o == (|delta_reg))
    else $error("modem interrupt not tied to changes");

  // Transmit flow stop
  chk_stop_hold: assert property (@(posedge ref_clk_i)
    disable iff (!nrst_i) tx_busy_i |=> $stable(tx_stop_o))
    else $error("flow stop changed mid character");
  chk_auto_off: assert property (@(posedge ref_clk_i)
    disable iff (!nrst_i) !auto_cts && !tx_busy_i |=> !tx_stop_o)
    else $error("flow stop while auto CTS disabled");

  cov_overrun: cover property (@(posedge ref_clk_i)
    disable iff (!nrst_i) rx_done_i && rx_fifo_full_i);
  cov_ring_edge: cover property (@(posedge ref_clk_i)
    disable iff (!nrst_i) delta_set[uls_pkg::MDM_RI]);
  cov_loop_cd: cover property (@(posedge ref_clk_i)
    disable iff (!nrst_i) loop_on && delta_set[uls_pkg::MDM_CD]);
  cov_tx_stop: cover property (@(posedge ref_clk_i)
    disable iff (!nrst_i) $rose(tx_stop_o));
endmodule

// ### sim/uls_modem_model.sv
// Modem model driving the four active-low control pins
module uls_modem_model (
  input wire logic [3:0] on_i,
  output logic cts_n_o,
  output logic dsr_n_o,
  output logic ri_n_o,
  output logic cd_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Push-pull pins, low while the signal is asserted
  assign cts_n_o = ~on_i[0];
  assign dsr_n_o = ~on_i[1];
  assign ri_n_o = ~on_i[2];
  assign cd_n_o = ~on_i[3];
endmodule

// ### sim/test_uls_status.sv
// Self-checking bench for the line and modem status block
module test_uls_status;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk_i = 1'b0, nrst_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
  logic [3:0] addr_i = 4'h0, on = 4'h0;
  logic [7:0] wdata_i = 8'h00, rdata_o;
  logic rx_done_i = 1'b0, rx_fifo_full_i = 1'b0, rx_avail_i = 1'b0;
  logic rx_top_perr_i = 1'b0, tx_busy_i = 1'b0;
  logic rx_push_o, tx_stop_o, modem_irq_o, irq_o;
  logic cd_n, ri_n, dsr_n, cts_n;
  int fails = 0, cmp_count = 0;

  uls_modem_model modem (.on_i(on), .cts_n_o(cts_n), .dsr_n_o(dsr_n),
    .ri_n_o(ri_n), .cd_n_o(cd_n));
  uls_status uut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .rx_done_i(rx_done_i), .rx_fifo_full_i(rx_fifo_full_i),
    .rx_avail_i(rx_avail_i), .rx_top_perr_i(rx_top_perr_i),
    .rx_push_o(rx_push_o), .tx_busy_i(tx_busy_i), .tx_stop_o(tx_stop_o),
    .cd_n_i(cd_n), .ri_n_i(ri_n), .dsr_n_i(dsr_n), .cts_n_i(cts_n),
    .modem_irq_o(modem_irq_o), .irq_o(irq_o));

  initial begin
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] m,
                    input logic [7:0] exp);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o & m, exp);
  endtask

  // Pin filter latency is only loosely fixed, so wait on the flag
  task automatic wait_irq();
    int k;
    for (k = 0; k < 20 && modem_irq_o !== 1'b1; k++) cyc(1);
    if (k == 20) begin
      chk(modem_irq_o, 8'h01);
      tally_and_finish();
    end
  endtask

  task automatic after_reset();
    rd(uls_pkg::OFS_LINE_STATUS, 8'hFF, 8'h00);
    rd(uls_pkg::OFS_MODEM_STATUS, 8'hFF, 8'h00);
    rd(4'hF, 8'hFF, 8'h00);
  endtask

  task automatic receive();
    @(posedge ref_clk_i);
    rx_avail_i <= 1'b1;
    rx_top_perr_i <= 1'b1;
    wr(uls_pkg::OFS_LINE_STATUS, 8'h02);
    rd(uls_pkg::OFS_LINE_STATUS, 8'hFF, 8'h05);
    @(posedge ref_clk_i);
    rx_done_i <= 1'b1;
    @(posedge ref_clk_i);
    rx_done_i <= 1'b0;
    #1;
    chk(rx_push_o, 1'b1);
    @(posedge ref_clk_i);
    rx_done_i <= 1'b1;
    rx_fifo_full_i <= 1'b1;
    rx_top_perr_i <= 1'b0;
    @(posedge ref_clk_i);
    rx_done_i <= 1'b0;
    #1;
    chk(rx_push_o, 1'b0);
    rd(uls_pkg::OFS_LINE_STATUS, 8'hFF, 8'h03);
    rd(uls_pkg::OFS_LINE_STATUS, 8'hFF, 8'h01);
    rx_avail_i <= 1'b0;
    rx_fifo_full_i <= 1'b0;
    rd(uls_pkg::OFS_LINE_STATUS, 8'hFF, 8'h00);
  endtask

  task automatic modem_pins();
    for (int i = 0; i < 4; i++) begin
      on[i] <= 1'b1;
      if (i == uls_pkg::MDM_RI) begin
        cyc(10);
        rd(uls_pkg::OFS_MODEM_STATUS, 8'hFF, {on, 4'h0});
      end else begin
        wait_irq();
        rd(uls_pkg::OFS_MODEM_STATUS, 8'hFF, {on, 4'h1 << i});
        rd(uls_pkg::OFS_MODEM_STATUS, 8'hFF, {on, 4'h0});
      end
      chk(modem_irq_o, 1'b0);
    end
    on <= 4'h0;
    wait_irq();
    cyc(10);
    rd(uls_pkg::OFS_MODEM_STATUS, 8'hFF, 8'h0F);
    rd(uls_pkg::OFS_MODEM_STATUS, 8'hFF, 8'h00);
  endtask

  task automatic loop_back();
    logic [3:0] k;
    logic [7:0] e;
    for (int j = 0; j < 16; j++) begin
      k = j[3:0];
      e = {k[3], k[2], k[0], k[1], 4'h0};
      wr(uls_pkg::OFS_MODEM_CTRL, {3'h0, 1'b1, k});
      rd(uls_pkg::OFS_MODEM_STATUS, 8'hC0, e & 8'hC0);
      rd(uls_pkg::OFS_MODEM_STATUS, 8'h30, e & 8'h30);
    end
    rd(uls_pkg::OFS_MODEM_CTRL, 8'hFF, 8'h1F);
    // Leaving loop-back drops all four bits, so all four changes latch
    wr(uls_pkg::OFS_MODEM_CTRL, 8'h00);
    cyc(10);
    rd(uls_pkg::OFS_MODEM_STATUS, 8'hFF, 8'h0F);
    rd(uls_pkg::OFS_MODEM_STATUS, 8'hFF, 8'h00);
  endtask

  task automatic flow();
    cyc(3);
    chk(tx_stop_o, 1'b0);
    wr(uls_pkg::OFS_FEATURE, 8'h80);
    cyc(3);
    chk(tx_stop_o, 1'b1);
    tx_busy_i <= 1'b1;
    on[uls_pkg::MDM_CTS] <= 1'b1;
    cyc(12);
    chk(tx_stop_o, 1'b1);
    tx_busy_i <= 1'b0;
    cyc(3);
    chk(tx_stop_o, 1'b0);
    on[uls_pkg::MDM_CTS] <= 1'b0;
    cyc(12);
    chk(tx_stop_o, 1'b1);
    wr(uls_pkg::OFS_FEATURE, 8'h00);
    rd(uls_pkg::OFS_MODEM_STATUS, 8'hFF, 8'h01);
  endtask

  // Earlier scenarios leave sticky events; check and clear them first
  task automatic overrun_irq(input logic [7:0] en, input logic exp,
                             input logic [7:0] stale);
    rd(uls_pkg::OFS_INT_STATUS, 8'hFF, stale);
    wr(uls_pkg::OFS_INT_CLEAR, 8'h07);
    wr(uls_pkg::OFS_INT_ENABLE, en);
    @(posedge ref_clk_i);
    rx_done_i <= 1'b1;
    rx_fifo_full_i <= 1'b1;
    @(posedge ref_clk_i);
    rx_done_i <= 1'b0;
    rx_fifo_full_i <= 1'b0;
    cyc(2);
    chk(irq_o, exp);
    rd(uls_pkg::OFS_INT_STATUS, 8'hFF, 8'h02);
    wr(uls_pkg::OFS_INT_CLEAR, 8'h02);
    cyc(2);
    chk(irq_o, 1'b0);
    rd(uls_pkg::OFS_INT_STATUS, 8'hFF, 8'h00);
    rd(uls_pkg::OFS_LINE_STATUS, 8'hFF, 8'h02);
  endtask

  initial begin
    cyc(16);
    nrst_i <= 1'b1;
    after_reset();
    receive();
    modem_pins();
    loop_back();
    flow();
    overrun_irq(8'h07, 1'b1, 8'h07);
    overrun_irq(8'h00, 1'b0, 8'h00);
    tally_and_finish();
  end
endmodule
